/* hdl/trigger_wake_ready_config.sv */
// Purpose: Configuration register for trigger acquisition, wake sources and ready pin
// Assumes: Register port and all pins synchronous to clk except the trigger pin
// Notes:   Status bits clear on writing one; set beats clear
`include "trigger_wake_ready_map.svh"
`timescale 1ns/100ps
`default_nettype none

module trigger_wake_ready_config #(
  parameter int DEC_WIDTH    = 13,
  parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire trigger_wake_ready_pkg::reg_req_s regReq,
  output logic [7:0]                           regRdata,
  output logic                                 irqOut,
  input  wire logic [DEC_WIDTH-1:0]            decimationCount,
  input  wire logic                            lowPowerMode,
  input  wire logic [1:0]                      bufferMode,
  input  wire logic                            bootModePin,
  input  wire logic                            outputRateTick,
  input  wire logic                            axisOutputRead,
  output logic                                 acqStart,
  input  wire logic                            acqDone,
  output logic                                 storeToOutput,
  output logic                                 storeToBuffer,
  output logic                                 sampleReadyFlag,
  input  wire logic                            withinBandEvent,
  input  wire logic                            outOfBandEvent,
  input  wire logic                            tiltChangeEvent,
  output logic                                 sleepBlock,
  output logic                                 wakeRequest,
  input  wire logic                            pinOneEvents,
  input  wire logic                            pinTwoEvents,
  input  wire logic                            pinOneReadyRoute,
  output logic                                 irqPinOneOut,
  output logic                                 irqPinOneOe,
  input  wire logic                            irqPinTwoIn,
  output logic                                 irqPinTwoOut,
  output logic                                 irqPinTwoOe,
  output logic                                 triggerActive
);

  // Refuse parameter values the counters cannot serve
  if (DEC_WIDTH < 1 || DEC_WIDTH > 16) begin : g_bad_dec_width
    $error("DEC_WIDTH out of range");
  end
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 4096) begin : g_bad_pulse_cycles
    $error("PULSE_CYCLES out of range");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  trigger_wake_ready_pkg::config_s cfg;
  logic [7:0]                      status;
  logic [7:0]                      mask;
  logic [7:0]                      next_status;
  logic [7:0]                      next_regRdata;
  logic [7:0]                      setEvents;
  logic                            wrCfg;
  logic                            wrStatus;
  logic                            wrMask;

  assign wrCfg    = regReq.wr && (regReq.addr == `CFG_OFFSET);
  assign wrStatus = regReq.wr && (regReq.addr == `STATUS_OFFSET);
  assign wrMask   = regReq.wr && (regReq.addr == `MASK_OFFSET);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= trigger_wake_ready_pkg::config_s'(`CFG_RESET);
    end else if (wrCfg) begin
      cfg <= trigger_wake_ready_pkg::config_s'(regReq.wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `MASK_RESET;
    end else if (wrMask) begin
      mask <= regReq.wdata;
    end
  end

  // Set wins over write-one-to-clear
  assign next_status = (status & ~(wrStatus ? regReq.wdata : 8'h00)) | setEvents;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    next_regRdata = 8'h00;
    if (regReq.rd) begin
      case (regReq.addr)
        `CFG_OFFSET:    next_regRdata = cfg;
        `STATUS_OFFSET: next_regRdata = status;
        `MASK_OFFSET:   next_regRdata = mask;
        default:        next_regRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  assign irqOut = |(status & mask);

  // ****************************************************************
  // Trigger input
  // ****************************************************************
  logic syncStage1;
  logic syncStage2;
  logic syncLast;
  logic trigEdge;

  // Trigger function needs pin two as input and is absent in motion mode
  assign triggerActive = cfg.pinTwoFunc && !bootModePin;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncStage1 <= 1'b0;
      syncStage2 <= 1'b0;
    end else begin
      syncStage1 <= irqPinTwoIn;
      syncStage2 <= syncStage1;
    end
  end

  // Edge history for the rising-edge detector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncLast <= 1'b0;
    end else begin
      syncLast <= syncStage2;
    end
  end

  assign trigEdge = triggerActive && syncStage2 && !syncLast;

  // ****************************************************************
  // Triggered acquisition sequencing
  // ****************************************************************
  trigger_wake_ready_pkg::acq_state_e acqState;
  logic [DEC_WIDTH-1:0]               acqCount;
  logic [DEC_WIDTH-1:0]               decTarget;
  logic                               multiMode;

  // Low power fixes decimation at one, making both modes identical
  assign decTarget = lowPowerMode ? DEC_WIDTH'(1) : decimationCount;
  // Mode bit only counts while the pin is the trigger input
  assign multiMode = triggerActive && cfg.trigMode && !lowPowerMode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acqState <= trigger_wake_ready_pkg::ACQ_IDLE;
      acqCount <= '0;
      acqStart <= 1'b0;
    end else begin
      acqStart <= 1'b0;
      case (acqState)
        trigger_wake_ready_pkg::ACQ_IDLE: begin
          if (!triggerActive) begin
            acqCount <= '0;
          end else if (trigEdge) begin
            acqStart <= 1'b1;
            acqState <= trigger_wake_ready_pkg::ACQ_RUN;
          end
        end
        trigger_wake_ready_pkg::ACQ_RUN: begin
          if (acqDone) begin
            if (acqCount + DEC_WIDTH'(1) >= decTarget) begin
              acqCount <= '0;
              acqState <= trigger_wake_ready_pkg::ACQ_STORE;
            end else begin
              acqCount <= acqCount + DEC_WIDTH'(1);
              if (multiMode) begin
                acqStart <= 1'b1;
              end else begin
                acqState <= trigger_wake_ready_pkg::ACQ_IDLE;
              end
            end
          end
        end
        trigger_wake_ready_pkg::ACQ_STORE: begin
          acqState <= trigger_wake_ready_pkg::ACQ_IDLE;
        end
        default: begin
          acqState <= trigger_wake_ready_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  logic storeNow;
  assign storeNow = (acqState == trigger_wake_ready_pkg::ACQ_STORE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      storeToOutput <= 1'b0;
    end else begin
      storeToOutput <= storeNow && (bufferMode == 2'b00);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      storeToBuffer <= 1'b0;
    end else begin
      storeToBuffer <= storeNow && (bufferMode != 2'b00);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleReadyFlag <= 1'b0;
    end else begin
      sampleReadyFlag <= storeNow && (bufferMode == 2'b00);
    end
  end

  // ****************************************************************
  // Auto wake and sleep sources
  // ****************************************************************
  logic withinGate;
  logic outsideGate;
  logic tiltGate;
  logic wakeSource;
  assign withinGate  = cfg.wakeWithin && withinBandEvent;
  assign outsideGate = cfg.wakeOutside && outOfBandEvent;
  assign tiltGate    = cfg.wakeTilt && tiltChangeEvent;
  assign wakeSource  = withinGate || outsideGate || tiltGate;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepBlock <= 1'b0;
    end else begin
      sleepBlock <= wakeSource;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= wakeSource;
    end
  end

  // ****************************************************************
  // Ready signalling on the interrupt pins
  // ****************************************************************
  logic        readyLevel;
  logic        pulseMode;
  logic [12:0] pulseCount;
  logic        readyPulse;
  logic        readySignal;
  logic        pinOneActive;
  logic        pinTwoActive;
  logic        polarity;

  // Motion detection mode ignores pulse select
  assign pulseMode = cfg.pulseSel && !bootModePin;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readyLevel <= 1'b0;
    end else if (sampleReadyFlag) begin
      readyLevel <= 1'b1;
    end else if (axisOutputRead) begin
      readyLevel <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseCount <= 13'h0000;
    end else if (pulseMode && outputRateTick) begin
      pulseCount <= 13'(PULSE_CYCLES);
    end else if (pulseCount != 13'h0000) begin
      pulseCount <= pulseCount - 13'h0001;
    end
  end

  assign readyPulse  = (pulseCount != 13'h0000);
  assign readySignal = pulseMode ? readyPulse : readyLevel;

  assign pinOneActive = pinOneEvents || (pinOneReadyRoute && readySignal);
  assign pinTwoActive = pinTwoEvents || (!pinOneReadyRoute && readySignal);

  // Motion detection mode forces active low
  assign polarity = bootModePin ? 1'b0 : cfg.polarity;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPinOneOut <= 1'b0;
    end else begin
      irqPinOneOut <= polarity ? pinOneActive : !pinOneActive;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPinTwoOut <= 1'b0;
    end else begin
      irqPinTwoOut <= polarity ? pinTwoActive : !pinTwoActive;
    end
  end

  assign irqPinOneOe = 1'b1;
  assign irqPinTwoOe = !triggerActive;

  // ****************************************************************
  // Status events
  // ****************************************************************
  assign setEvents = {5'h00, wakeSource, trigEdge, sampleReadyFlag};

endmodule : trigger_wake_ready_config

`default_nettype wire

/* hdl/trigger_wake_ready_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz core clock
// Notes:   Definitions only
`ifndef TRIGGER_WAKE_READY_MAP_SVH
`define TRIGGER_WAKE_READY_MAP_SVH

`define CFG_OFFSET        8'h18
`define STATUS_OFFSET     8'h19
`define MASK_OFFSET       8'h1A
`define CFG_RESET         8'h01
`define STATUS_RESET      8'h00
`define MASK_RESET        8'h00
`define BIT_TRIG_MODE     7
`define BIT_WAKE_WITHIN   6
`define BIT_WAKE_OUTSIDE  5
`define BIT_WAKE_TILT     4
`define BIT_PULSE_SEL     3
`define BIT_PIN_TWO_FUNC  2
`define BIT_DRIVER_TYPE   1
`define BIT_POLARITY      0
`define EVT_READY         0
`define EVT_TRIGGER       1
`define EVT_WAKE          2
`define PULSE_TIME_NS     32000
`define CLK_PERIOD_NS     100
`define PULSE_CYCLES      ((`PULSE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* hdl/trigger_wake_ready_pkg.sv */
// Purpose: Types for the trigger, wake and ready configuration block
// Assumes: Nothing
// Notes:   Constants live in trigger_wake_ready_map.svh
package trigger_wake_ready_pkg;

  typedef struct packed {
    logic trigMode;
    logic wakeWithin;
    logic wakeOutside;
    logic wakeTilt;
    logic pulseSel;
    logic pinTwoFunc;
    logic driverType;
    logic polarity;
  } config_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef enum logic [2:0] {
    ACQ_IDLE  = 3'b001,
    ACQ_RUN   = 3'b010,
    ACQ_STORE = 3'b100
  } acq_state_e;

endpackage : trigger_wake_ready_pkg

/* sim/host_trigger_model.sv */
// Purpose: Host side that drives the trigger pin
// Assumes: Host timer output is push-pull and low between requests
// Notes:   HOLD sets how many cycles each trigger pulse stays high
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Trigger pulse generator
// ****************************************
module host_trigger_model #(
  parameter int HOLD = 4
) (
  input  wire logic clk,
  input  wire logic fire,
  output var logic  trigPin
);
  int cnt;
  initial trigPin = 1'b0;
  initial cnt = 0;
  // One rising edge per measurement request
  always @(posedge clk) begin
    if (fire) begin
      trigPin <= 1'b1;
      cnt <= HOLD;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      trigPin <= 1'b0;
      cnt <= 0;
    end
  end
endmodule : host_trigger_model
`default_nettype wire

/* sim/trigger_wake_ready_config_properties.sv */
// Purpose: Port checks for the trigger, wake and ready block
// Assumes: Config changes only through register writes
// Notes:   Shadow config tracks the register write by write
`include "trigger_wake_ready_map.svh"
`timescale 1ns/100ps
`default_nettype none
module trigger_wake_ready_config_properties (
  input wire logic                             clk,
  input wire logic                             rst_n,
  input wire trigger_wake_ready_pkg::reg_req_s regReq,
  input wire logic [7:0]                       regRdata,
  input wire logic [1:0]                       bufferMode,
  input wire logic                             bootModePin,
  input wire logic                             outputRateTick,
  input wire logic                             acqStart,
  input wire logic                             storeToOutput,
  input wire logic                             sampleReadyFlag,
  input wire logic                             withinBandEvent,
  input wire logic                             outOfBandEvent,
  input wire logic                             tiltChangeEvent,
  input wire logic                             sleepBlock,
  input wire logic                             wakeRequest,
  input wire logic                             pinOneEvents,
  input wire logic                             pinOneReadyRoute,
  input wire logic                             irqPinOneOut,
  input wire logic                             irqPinTwoOe,
  input wire logic                             triggerActive
);
  logic [7:0] cfg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cfg <= `CFG_RESET;
    else if (regReq.wr && regReq.addr == `CFG_OFFSET) cfg <= regReq.wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wake; {sleepBlock, wakeRequest} ==
    {2{|$past({withinBandEvent, outOfBandEvent, tiltChangeEvent} & cfg[6:4])}}; endproperty
  a_wake: assert property (p_wake) else $error("wake source mismatch");
  property p_acq_gate; acqStart |-> $past(triggerActive); endproperty
  a_acq_gate: assert property (p_acq_gate) else $error("acquisition without trigger");
  property p_ready_buf; sampleReadyFlag |-> storeToOutput && $past(bufferMode) == 2'b00; endproperty
  a_ready_buf: assert property (p_ready_buf) else $error("ready flag in buffer mode");
  property p_pin_two; triggerActive |-> !irqPinTwoOe; endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin two driven as input");
  property p_level; sampleReadyFlag && !cfg[3] && pinOneReadyRoute && !bootModePin
    |-> ##2 irqPinOneOut == cfg[0]; endproperty
  a_level: assert property (p_level) else $error("ready level missing");
  property p_pulse; outputRateTick && cfg[3] && pinOneReadyRoute && !bootModePin
    |-> ##2 irqPinOneOut == cfg[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("ready pulse missing");
  property p_or; pinOneEvents [*2] ##0 !bootModePin |-> irqPinOneOut == cfg[0]; endproperty
  a_or: assert property (p_or) else $error("other event not on pin");
  property p_rdata; !$past(regReq.rd) |-> regRdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not idle");
endmodule : trigger_wake_ready_config_properties
bind trigger_wake_ready_config trigger_wake_ready_config_properties u_props (.clk, .rst_n,
  .regReq, .regRdata, .bufferMode, .bootModePin, .outputRateTick, .acqStart, .storeToOutput,
  .sampleReadyFlag, .withinBandEvent, .outOfBandEvent, .tiltChangeEvent, .sleepBlock,
  .wakeRequest, .pinOneEvents, .pinOneReadyRoute, .irqPinOneOut, .irqPinTwoOe, .triggerActive);
`default_nettype wire

/* sim/test_trigger_wake_ready_config.sv */
// Purpose: Self-checking bench for the trigger, wake and ready block
// Assumes: Decimation 3, ready pulse shortened to 4 cycles
// Notes:   Each acquisition completes one cycle after it starts
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_trigger_wake_ready_config;
  logic                             clk, rst_n, lowPowerMode, bootModePin, outputRateTick;
  logic                             axisOutputRead, acqStart, acqDone, storeToOutput, irqOut;
  logic                             storeToBuffer, sampleReadyFlag, sleepBlock, wakeRequest;
  logic                             pinOneEvents, pinOneReadyRoute, irqPinOneOut, fire, trig;
  logic                             irqPinTwoOut, irqPinTwoOe, triggerActive, pinTwoEvents;
  logic [2:0]                       ev;
  logic [1:0]                       bufferMode;
  logic [7:0]                       regRdata;
  trigger_wake_ready_pkg::reg_req_s regReq;
  int                               errCount, nTests, nAcq, nStO, nStB, nRdy, n;
  wire logic                        irqPinTwoIn = irqPinTwoOe ? irqPinTwoOut : trig;
  trigger_wake_ready_config #(.PULSE_CYCLES(4)) u_trigger_wake_ready_config (
    .clk, .rst_n, .regReq, .regRdata, .irqOut, .decimationCount(13'h0003), .lowPowerMode,
    .bufferMode, .bootModePin, .outputRateTick, .axisOutputRead, .acqStart, .acqDone,
    .storeToOutput, .storeToBuffer, .sampleReadyFlag, .withinBandEvent(ev[2]),
    .outOfBandEvent(ev[1]), .tiltChangeEvent(ev[0]), .sleepBlock, .wakeRequest,
    .pinOneEvents, .pinTwoEvents, .pinOneReadyRoute, .irqPinOneOut, .irqPinOneOe(),
    .irqPinTwoIn, .irqPinTwoOut, .irqPinTwoOe, .triggerActive);
  host_trigger_model u_host_trigger_model (.clk, .fire, .trigPin(trig));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ADC stand-in and event counters
  always @(posedge clk) begin
    acqDone <= acqStart;
    nAcq += acqStart;
    nStO += storeToOutput;
    nStB += storeToBuffer;
    nRdy += sampleReadyFlag;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) regReq <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) regReq <= '0;
    #1 `CHK(regRdata, e)
  endtask : rd
  // Sel 0 fires the trigger, 1 ticks the output rate, 2 reads an axis register
  task automatic pulse(input int sel);
    @(posedge clk) begin
      fire           <= (sel == 0);
      outputRateTick <= (sel == 1);
      axisOutputRead <= (sel == 2);
    end
    @(posedge clk) {fire, outputRateTick, axisOutputRead} <= 3'b000;
  endtask : pulse
  task automatic trigOnce();
    pulse(0);
    repeat (20) @(posedge clk);
  endtask : trigOnce
  task automatic tickCount(input logic act);
    n = 0;
    pulse(1);
    repeat (12) begin
      @(posedge clk);
      #1 n += (irqPinOneOut === act);
    end
  endtask : tickCount
  task automatic endSim();
    if (errCount == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : endSim
  initial begin
    #(100 * 5000);
    errCount++;
    endSim();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst_n, lowPowerMode, bootModePin, outputRateTick, axisOutputRead} = '0;
    {pinOneEvents, pinTwoEvents, fire, ev, bufferMode} = '0;
    pinOneReadyRoute = 1'b1;
    regReq = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h18, 8'h01);
    rd(8'h19, 8'h00);
    rd(8'h1A, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h18, 8'hF6);
    rd(8'h18, 8'hF6);
    for (int i = 0; i < 3; i++) begin
      wr(8'h18, 8'h01 | (8'h40 >> i));
      ev <= 3'b100 >> i;
      repeat (3) @(posedge clk);
      #1 `CHK({sleepBlock, wakeRequest}, 2'b11)
      wr(8'h18, 8'h71 ^ (8'h40 >> i));
      repeat (3) @(posedge clk);
      #1 `CHK({sleepBlock, wakeRequest}, 2'b00)
    end
    @(posedge clk) ev <= '0;
    wr(8'h19, 8'hFF);
    wr(8'h18, 8'h05);
    #1 `CHK(triggerActive, 1'b1)
    for (int i = 1; i <= 3; i++) begin
      trigOnce();
      `CHK(nAcq, i)
    end
    `CHK(nStO, 1)
    `CHK(nRdy, 1)
    `CHK(irqPinOneOut, 1'b1)
    rd(8'h19, 8'h03);
    wr(8'h1A, 8'h02);
    #1 `CHK(irqOut, 1'b1)
    wr(8'h19, 8'h02);
    #1 `CHK(irqOut, 1'b0)
    rd(8'h19, 8'h01);
    pulse(2);
    repeat (2) @(posedge clk);
    #1 `CHK(irqPinOneOut, 1'b0)
    wr(8'h18, 8'h85);
    for (int i = 0; i < 3; i++) begin
      bufferMode <= (i == 1) ? 2'b01 : 2'b00;
      lowPowerMode <= (i == 2);
      trigOnce();
    end
    `CHK(nAcq, 10)
    `CHK(nStO, 3)
    `CHK(nStB, 1)
    `CHK(nRdy, 3)
    lowPowerMode <= 1'b0;
    bufferMode <= 2'b00;
    wr(8'h18, 8'h81);
    trigOnce();
    `CHK(nAcq, 10)
    `CHK(irqPinTwoOe, 1'b1)
    `CHK(triggerActive, 1'b0)
    pinTwoEvents <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(irqPinTwoOut, 1'b1)
    @(posedge clk) pinTwoEvents <= 1'b0;
    pulse(2);
    for (int p = 0; p < 2; p++) begin
      wr(8'h18, 8'h08 | 8'(p));
      tickCount(1'(p));
      `CHK(n, 4)
    end
    pinOneEvents <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK(irqPinOneOut, 1'b1)
    @(posedge clk) pinOneEvents <= 1'b0;
    bootModePin <= 1'b1;
    wr(8'h18, 8'h0D);
    #1 `CHK(triggerActive, 1'b0)
    tickCount(1'b0);
    `CHK(n, 0)
    endSim();
  end
endmodule : test_trigger_wake_ready_config
`default_nettype wire
